// ### rtl/ucg_clock_gen.sv
// Purpose: baud generator and transfer clock handling of a serial unit
// Assumes: classic Wishbone slave, single 10 MHz clock, sync reset
// Notes: all outputs registered; ticks are one-cycle pulses
//
// Overview of operation
// - four clock modes: normal async, double async, sync master, sync slave
// - sync select bit low gives asynchronous, high gives synchronous operation
// - in sync mode pin direction picks master (driven) or slave (sampled)
// - transfer clock pin is only used while synchronous mode is selected
// - down-counter reloads divisor at zero and on divisor low-byte write
// - one baud pulse each time counter hits zero: clock over divisor+1
// - transmitter clock is baud output divided by 2, 8 or 16 by mode
// - receiver takes baud output undivided, state machine of 2, 8 or 16
// - bit rate clock over 16, 8 or 2 times divisor+1
// - divisor is twelve bits, high and low byte registers
// - double speed bit only acts in asynchronous operation
// - double speed gives receiver 8 samples per bit instead of 16
// - slave clock passes synchroniser then edge detector, four clocks from pin to rx tick
// - separate base clocks for transmitter and receiver
// - baud generator feeds async and master modes, pin feeds slave mode
// - sync data sampled on edge opposite change edge, polarity picks which
`timescale 1ns/1ps

module ucg_clock_gen #(
  parameter int DIV_WIDTH = 12 // divisor width
) (
  input wire logic clk_i, // system clock
  input wire logic rst_i, // synchronous reset, active high
  input wire logic wb_cyc_i, // bus cycle
  input wire logic wb_stb_i, // bus strobe
  input wire logic wb_we_i, // write enable
  input wire logic [7:0] wb_adr_i, // byte address
  input wire logic [3:0] wb_sel_i, // byte lanes
  input wire logic [31:0] wb_dat_i, // write data
  output logic [31:0] wb_dat_o, // read data
  output logic wb_ack_o, // acknowledge
  input wire logic xck_i, // transfer clock pin, input side
  output logic xck_o, // transfer clock pin, output side
  output logic xck_oe_o, // transfer clock pin, output enable
  output logic tx_tick_o, // transmitter base clock pulse
  output logic rx_tick_o, // receiver base clock pulse
  output logic rx_sample_o, // sync mode data sample pulse
  output logic [3:0] rx_state_o // receiver recovery state
);

  // ***********************************************************
  // bus decode
  // ***********************************************************
  ucg_pkg::ucg_cfg_t cfg_reg;
  ucg_pkg::ucg_cfg_t cfg_next;
  ucg_pkg::ucg_mode_t mode_reg;
  ucg_pkg::ucg_mode_t mode_next;
  logic [11:0] cnt_reg;
  logic [11:0] cnt_next;
  logic [3:0] txdiv_reg;
  logic [3:0] txdiv_next;
  logic [3:0] rxst_reg;
  logic [3:0] rxst_next;
  logic xck_s1_reg;
  logic xck_s2_reg;
  logic xck_s3_reg;
  logic xrise_reg;
  logic xfall_reg;
  logic ack_reg;

  // a request is answered one cycle after it is seen, once
  wire req = wb_cyc_i && wb_stb_i && !ack_reg;
  wire wr0 = req && wb_we_i && wb_sel_i[0];
  wire wr1 = req && wb_we_i && wb_sel_i[1];
  wire wr_c = wr0 && (wb_adr_i == ucg_pkg::ADR_CTRL_C);
  wire wr_a = wr0 && (wb_adr_i == ucg_pkg::ADR_CTRL_A);
  wire wr_lo = wr0 && (wb_adr_i == ucg_pkg::ADR_DIV_LO);
  wire wr_hi = wr0 && (wb_adr_i == ucg_pkg::ADR_DIV_HI);
  wire wr_dir = wr0 && (wb_adr_i == ucg_pkg::ADR_PINDIR);
  wire wr_pwr = wr0 && (wb_adr_i == ucg_pkg::ADR_POWER);
  wire unused_lane = wr1; // upper lanes carry no fields

  // read mux, unmapped and reserved bits read zero
  wire [31:0] rd_c = {30'h0, cfg_reg.sync_clock_polarity, cfg_reg.sync_mode_select};
  wire [31:0] rd_a = {30'h0, cfg_reg.double_speed_bit, 1'b0};
  wire [31:0] rd_lo = {24'h0, cfg_reg.baud_divisor[7:0]};
  wire [31:0] rd_hi = {28'h0, cfg_reg.baud_divisor[11:8]};
  wire [31:0] rd_dir = {31'h0, cfg_reg.xfer_clock_direction};
  wire [31:0] rd_pwr = {31'h0, cfg_reg.power_cut};
  wire [31:0] rd_st = {4'h0, cnt_reg, 4'h0, rxst_reg, 4'h0, mode_reg};
  wire [31:0] rd_mux =
    (wb_adr_i == ucg_pkg::ADR_CTRL_C) ? rd_c :
    (wb_adr_i == ucg_pkg::ADR_CTRL_A) ? rd_a :
    (wb_adr_i == ucg_pkg::ADR_DIV_LO) ? rd_lo :
    (wb_adr_i == ucg_pkg::ADR_DIV_HI) ? rd_hi :
    (wb_adr_i == ucg_pkg::ADR_PINDIR) ? rd_dir :
    (wb_adr_i == ucg_pkg::ADR_POWER) ? rd_pwr :
    (wb_adr_i == ucg_pkg::ADR_STATUS) ? rd_st : 32'h0000_0000;

  // ***********************************************************
  // configuration registers
  // ***********************************************************
  // divisor stored as twelve bits, high byte keeps only 4 bits
  always_comb begin
    cfg_next = cfg_reg;
    if (wr_c) begin
      cfg_next.sync_mode_select = wb_dat_i[ucg_pkg::BIT_SYNC];
      cfg_next.sync_clock_polarity = wb_dat_i[ucg_pkg::BIT_POL];
    end
    if (wr_a) begin
      cfg_next.double_speed_bit = wb_dat_i[ucg_pkg::BIT_DBL];
    end
    if (wr_lo) begin
      cfg_next.baud_divisor[7:0] = wb_dat_i[7:0];
    end
    if (wr_hi) begin
      cfg_next.baud_divisor[11:8] = wb_dat_i[3:0];
    end
    if (wr_dir) begin
      cfg_next.xfer_clock_direction = wb_dat_i[ucg_pkg::BIT_DIR];
    end
    if (wr_pwr) begin
      cfg_next.power_cut = wb_dat_i[ucg_pkg::BIT_PWR];
    end
  end

  // mode from sync select, pin direction and double speed
  always_comb begin
    if (!cfg_reg.sync_mode_select) begin
      mode_next = cfg_reg.double_speed_bit ? ucg_pkg::UCG_ASYNC_DOUBLE : ucg_pkg::UCG_ASYNC_NORMAL;
    end else if (cfg_reg.xfer_clock_direction) begin
      mode_next = ucg_pkg::UCG_SYNC_MASTER;
    end else begin
      mode_next = ucg_pkg::UCG_SYNC_SLAVE;
    end
  end

  // ***********************************************************
  // baud down-counter
  // ***********************************************************
  // power cut freezes the counter so no pulses leave the unit
  wire run = !cfg_reg.power_cut;
  wire baud_tick = run && (cnt_reg == 12'h000);
  wire [11:0] div_new = {cfg_reg.baud_divisor[11:8], wb_dat_i[7:0]};
  assign cnt_next = wr_lo ? div_new :
                    !run ? cnt_reg :
                    baud_tick ? cfg_reg.baud_divisor :
                    cnt_reg - 12'h001;

  // ***********************************************************
  // transfer clock pin: synchroniser and edge detector
  // ***********************************************************
  // s1 feeds s2 only; the detector compares s2 with s3
  wire is_slave = (mode_reg == ucg_pkg::UCG_SYNC_SLAVE);
  wire is_master = (mode_reg == ucg_pkg::UCG_SYNC_MASTER);
  wire x_rise = xck_s2_reg && !xck_s3_reg;
  wire x_fall = !xck_s2_reg && xck_s3_reg;

  // ***********************************************************
  // edge selection for synchronous modes
  // ***********************************************************
  // master edges come from toggling the pin on each baud pulse
  wire m_rise = is_master && baud_tick && !xck_o;
  wire m_fall = is_master && baud_tick && xck_o;
  wire s_rise = is_slave && xrise_reg && run;
  wire s_fall = is_slave && xfall_reg && run;
  wire any_rise = m_rise || s_rise;
  wire any_fall = m_fall || s_fall;
  // polarity low: change on rising, sample on falling
  wire sync_change = cfg_reg.sync_clock_polarity ? any_fall : any_rise;
  wire sync_sample = cfg_reg.sync_clock_polarity ? any_rise : any_fall;

  // ***********************************************************
  // transmitter divider and receiver state
  // ***********************************************************
  logic [3:0] last_step;
  always_comb begin
    case (mode_reg)
      ucg_pkg::UCG_ASYNC_NORMAL: last_step = ucg_pkg::LAST_NORMAL;
      ucg_pkg::UCG_ASYNC_DOUBLE: last_step = ucg_pkg::LAST_DOUBLE;
      ucg_pkg::UCG_SYNC_MASTER: last_step = ucg_pkg::LAST_SYNC;
      ucg_pkg::UCG_SYNC_SLAVE: last_step = ucg_pkg::LAST_SYNC;
      default: last_step = ucg_pkg::LAST_NORMAL;
    endcase
  end

  // rx base pulse: baud output, or either pin edge in slave mode
  wire rx_base = is_slave ? (s_rise || s_fall) : baud_tick;
  wire async_tx = !mode_reg[2] && !mode_reg[3] && baud_tick && (txdiv_reg == last_step);
  wire tx_base = async_tx || sync_change;
  assign txdiv_next = (!baud_tick || is_slave) ? txdiv_reg :
                      (txdiv_reg >= last_step) ? 4'h0 : txdiv_reg + 4'h1;
  assign rxst_next = !rx_base ? rxst_reg :
                     (rxst_reg >= last_step) ? 4'h0 : rxst_reg + 4'h1;

  // ***********************************************************
  // registers
  // ***********************************************************
  // reset state: counter zero, normal async, double speed off
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cfg_reg <= '{ucg_pkg::RST_SYNC, ucg_pkg::RST_POL, ucg_pkg::RST_DBL,
                   ucg_pkg::RST_DIR, ucg_pkg::RST_PWR, ucg_pkg::DIV_RST};
      mode_reg <= ucg_pkg::UCG_ASYNC_NORMAL;
      cnt_reg <= ucg_pkg::DIV_RST;
      txdiv_reg <= 4'h0;
      rxst_reg <= 4'h0;
    end else begin
      cfg_reg <= cfg_next;
      mode_reg <= mode_next;
      cnt_reg <= cnt_next;
      txdiv_reg <= txdiv_next;
      rxst_reg <= rxst_next;
    end
  end

  // pin sampling chain, two flops before any reader
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      xck_s1_reg <= 1'b0;
      xck_s2_reg <= 1'b0;
      xck_s3_reg <= 1'b0;
      xrise_reg <= 1'b0;
      xfall_reg <= 1'b0;
    end else begin
      xck_s1_reg <= xck_i;
      xck_s2_reg <= xck_s1_reg;
      xck_s3_reg <= xck_s2_reg;
      xrise_reg <= x_rise;
      xfall_reg <= x_fall;
    end
  end

  // outputs; pin is released outside synchronous master mode
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      xck_o <= 1'b0;
      xck_oe_o <= 1'b0;
      tx_tick_o <= 1'b0;
      rx_tick_o <= 1'b0;
      rx_sample_o <= 1'b0;
      rx_state_o <= 4'h0;
      wb_ack_o <= 1'b0;
      ack_reg <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end else begin
      xck_o <= is_master ? (xck_o ^ baud_tick) : cfg_reg.sync_clock_polarity;
      xck_oe_o <= is_master;
      tx_tick_o <= tx_base;
      rx_tick_o <= rx_base;
      rx_sample_o <= sync_sample;
      rx_state_o <= rxst_next;
      wb_ack_o <= req;
      ack_reg <= req;
      wb_dat_o <= req ? rd_mux : 32'h0000_0000;
    end
  end

  // ***********************************************************
  // checks
  // ***********************************************************
  baud_reload_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (baud_tick && !wr_lo) |=> (cnt_reg == $past(cfg_reg.baud_divisor)))
    else $error("counter did not reload at zero");
  low_write_reload_a: assert property (@(posedge clk_i) disable iff (rst_i)
    wr_lo |=> (cnt_reg == cfg_reg.baud_divisor))
    else $error("low byte write did not reload counter");
  count_down_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (run && !baud_tick && !wr_lo) |=> (cnt_reg == $past(cnt_reg) - 12'h001))
    else $error("counter did not step down");
  tx_from_baud_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (tx_tick_o && !$past(is_slave)) |-> $past(baud_tick))
    else $error("tx pulse without baud pulse");
  rx_undivided_a: assert property (@(posedge clk_i) disable iff (rst_i)
    !is_slave |=> (rx_tick_o == $past(baud_tick)))
    else $error("rx base not the baud output");
  double_wrap_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (mode_reg == ucg_pkg::UCG_ASYNC_DOUBLE && rx_base && rxst_reg == 4'h7) |=> (rxst_reg == 4'h0))
    else $error("double speed state did not wrap at 8");
  slave_edge_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (xck_s2_reg && !xck_s3_reg) |=> xrise_reg)
    else $error("slave edge not detected");
  pin_release_a: assert property (@(posedge clk_i) disable iff (rst_i)
    1'b1 |=> (xck_oe_o == $past(is_master)))
    else $error("pin driven outside master mode");
  reset_state_a: assert property (@(posedge clk_i) disable iff (rst_i)
    $fell(rst_i) |-> (cnt_reg == 12'h000 && mode_reg == ucg_pkg::UCG_ASYNC_NORMAL))
    else $error("bad state after reset");

  // ***********************************************************
  // mode and pin checks
  // ***********************************************************
  // mode lags config by one cycle, so check against the config seen
  async_select_a: assert property (@(posedge clk_i) disable iff (rst_i)
    !cfg_reg.sync_mode_select |=> (!mode_reg[2] && !mode_reg[3]))
    else $error("async select gave a sync mode");
  master_select_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (cfg_reg.sync_mode_select && cfg_reg.xfer_clock_direction) |=> (mode_reg == ucg_pkg::UCG_SYNC_MASTER))
    else $error("driven pin did not give master mode");
  slave_select_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (cfg_reg.sync_mode_select && !cfg_reg.xfer_clock_direction) |=> (mode_reg == ucg_pkg::UCG_SYNC_SLAVE))
    else $error("sampled pin did not give slave mode");
  double_ignored_a: assert property (@(posedge clk_i) disable iff (rst_i)
    cfg_reg.sync_mode_select |=> (mode_reg != ucg_pkg::UCG_ASYNC_DOUBLE))
    else $error("double speed acted in sync mode");
  pin_idle_level_a: assert property (@(posedge clk_i) disable iff (rst_i)
    !is_master |=> (xck_o == $past(cfg_reg.sync_clock_polarity)))
    else $error("pin output not at idle level");
  master_toggle_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (is_master && baud_tick) |=> (xck_o != $past(xck_o)))
    else $error("master clock did not toggle");

  // ***********************************************************
  // counter, tick and state checks
  // ***********************************************************
  // power cut must hold the counter, else ticks leak while cut
  power_freeze_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (!run && !wr_lo) |=> (cnt_reg == $past(cnt_reg)))
    else $error("counter moved while power cut");
  cut_no_tick_a: assert property (@(posedge clk_i) disable iff (rst_i)
    !run |=> !rx_tick_o)
    else $error("rx tick while power cut");
  async_no_sample_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (!is_master && !is_slave) |=> !rx_sample_o)
    else $error("sample pulse in async mode");
  master_change_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (is_master && baud_tick && !xck_o && !cfg_reg.sync_clock_polarity) |=> tx_tick_o)
    else $error("no tx pulse on master change edge");
  master_sample_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (is_master && baud_tick && xck_o && !cfg_reg.sync_clock_polarity) |=> rx_sample_o)
    else $error("no sample on opposite edge");
  normal_wrap_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (mode_reg == ucg_pkg::UCG_ASYNC_NORMAL && rx_base && rxst_reg == 4'hF) |=> (rxst_reg == 4'h0))
    else $error("normal state did not wrap at 16");
  sync_wrap_a: assert property (@(posedge clk_i) disable iff (rst_i)
    ((is_master || is_slave) && rx_base && rxst_reg >= 4'h1) |=> (rxst_reg == 4'h0))
    else $error("sync state did not wrap at 2");
  slave_tick_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (is_slave && run && (xrise_reg || xfall_reg)) |=> rx_tick_o)
    else $error("pin edge gave no rx tick");
  sync_chain_a: assert property (@(posedge clk_i) disable iff (rst_i)
    1'b1 |=> (xck_s2_reg == $past(xck_s1_reg)))
    else $error("synchroniser stage skipped");

  // bus answer: one-cycle ack, data zero when no ack
  ack_pulse_a: assert property (@(posedge clk_i) disable iff (rst_i)
    wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");
  idle_data_a: assert property (@(posedge clk_i) disable iff (rst_i)
    !wb_ack_o |-> (wb_dat_o == 32'h0000_0000))
    else $error("read data without ack");

endmodule : ucg_clock_gen

// ### rtl/ucg_pkg.sv
// Purpose: shared constants and types of the serial clock generator
// Assumes: 32-bit classic Wishbone register access, one system clock
// Notes: byte addresses, one aligned word per register
package ucg_pkg;

  // ***********************************************************
  // register map
  // ***********************************************************
  localparam logic [7:0] ADR_CTRL_C = 8'h00; // sync select, polarity
  localparam logic [7:0] ADR_CTRL_A = 8'h04; // double speed
  localparam logic [7:0] ADR_DIV_LO = 8'h08; // divisor bits 7:0
  localparam logic [7:0] ADR_DIV_HI = 8'h0C; // divisor bits 11:8
  localparam logic [7:0] ADR_PINDIR = 8'h10; // transfer clock direction
  localparam logic [7:0] ADR_POWER = 8'h14; // power cut
  localparam logic [7:0] ADR_STATUS = 8'h18; // read-only state

  // ***********************************************************
  // field positions
  // ***********************************************************
  localparam int BIT_SYNC = 0; // control_status_c
  localparam int BIT_POL = 1; // control_status_c
  localparam int BIT_DBL = 1; // control_status_a
  localparam int BIT_DIR = 0; // pin direction register
  localparam int BIT_PWR = 0; // power register
  localparam int STAT_MODE_LSB = 0; // status: mode code, 4 bits
  localparam int STAT_RXST_LSB = 8; // status: receiver state, 4 bits
  localparam int STAT_CNT_LSB = 16; // status: down-counter, 12 bits

  // ***********************************************************
  // widths, reset values, division figures
  // ***********************************************************
  localparam int DIV_W = 12;
  localparam logic [11:0] DIV_RST = 12'h000;
  localparam logic RST_SYNC = 1'b0;
  localparam logic RST_POL = 1'b0;
  localparam logic RST_DBL = 1'b0;
  localparam logic RST_DIR = 1'b0;
  localparam logic RST_PWR = 1'b0;
  localparam logic [3:0] LAST_NORMAL = 4'hF; // 16 steps per bit
  localparam logic [3:0] LAST_DOUBLE = 4'h7; // 8 steps per bit
  localparam logic [3:0] LAST_SYNC = 4'h1; // 2 steps per bit
  localparam int CLK_PERIOD_NS = 100; // 10 MHz system clock

  // ***********************************************************
  // types
  // ***********************************************************
  typedef enum logic [3:0] {
    UCG_ASYNC_NORMAL = 4'b0001,
    UCG_ASYNC_DOUBLE = 4'b0010,
    UCG_SYNC_MASTER = 4'b0100,
    UCG_SYNC_SLAVE = 4'b1000
  } ucg_mode_t;

  typedef struct packed {
    logic sync_mode_select;
    logic sync_clock_polarity;
    logic double_speed_bit;
    logic xfer_clock_direction;
    logic power_cut;
    logic [11:0] baud_divisor;
  } ucg_cfg_t;

endpackage : ucg_pkg

// ### tb/ucg_peer.sv
// Purpose: serial peer that owns the transfer clock in slave mode
// Assumes: pin level is resolved by the bench from the design's output enable
// Notes: clock stands at the idle level outside frames
`timescale 1ns/1ps

module ucg_peer #(
  parameter int HALF = 6 // half period in system clocks
) (
  input wire logic clk_i, // system clock
  input wire logic run_i, // frame in progress
  input wire logic pol_i, // idle level of the clock
  output logic drv_o // clock level offered to the pin
);
  int cnt = 0;

  initial drv_o = 1'h0;

  // twelve-cycle period keeps well under a quarter of the system rate
  always @(posedge clk_i) begin
    if (!run_i) begin
      drv_o <= pol_i;
      cnt <= 0;
    end else if (cnt == HALF - 1) begin
      drv_o <= ~drv_o;
      cnt <= 0;
    end else begin
      cnt <= cnt + 1;
    end
  end
endmodule : ucg_peer

// ### tb/tb_usart_clock_generator.sv
// Purpose: self-checking bench of the serial clock generator
// Assumes: classic Wishbone, ack one cycle after the request
// Notes: pin driven by the design when enabled, else by the peer
`timescale 1ns/1ps
`define CHK(n, e, g) begin n_compared++; if ((g) !== (e)) begin n_errors++; \
  $display("mismatch %s exp %0h got %0h", n, e, g); end end

module tb_usart_clock_generator;
  logic clk_i = 1'h0, rst_i = 1'h1, wb_cyc_i = 1'h0, wb_stb_i = 1'h0, wb_we_i = 1'h0;
  logic [7:0] wb_adr_i = 8'h00;
  logic [3:0] wb_sel_i = 4'h0, rx_state_o;
  logic [31:0] wb_dat_i = 32'h0, wb_dat_o;
  logic wb_ack_o, xck_o, xck_oe_o, tx_tick_o, rx_tick_o, rx_sample_o, xck_q, pin_q;
  logic peer_run = 1'h0, peer_pol = 1'h0;
  wire xck_peer;
  wire xck_i = xck_oe_o ? xck_o : xck_peer;
  int n_errors = 0, n_compared = 0, cyc_n = 0;

  ucg_clock_gen ucg_clock_gen_i (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
    .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .xck_i(xck_i),
    .xck_o(xck_o), .xck_oe_o(xck_oe_o), .tx_tick_o(tx_tick_o), .rx_tick_o(rx_tick_o),
    .rx_sample_o(rx_sample_o), .rx_state_o(rx_state_o));
  ucg_peer ucg_peer_i (.clk_i(clk_i), .run_i(peer_run), .pol_i(peer_pol), .drv_o(xck_peer));

  initial forever #50 clk_i = ~clk_i;

  // previous pin levels, for edge detection at the sampling point
  always @(posedge clk_i) begin
    xck_q <= xck_o;
    pin_q <= xck_i;
    cyc_n++;
    if (cyc_n == 80000) begin
      n_errors++;
      summarize();
    end
  end

  task summarize;
    $display("counts: %0d compared, %0d mismatches", n_compared, n_errors);
    if (n_errors == 0 && n_compared > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : summarize

  function automatic logic sig(int w);
    case (w)
      0: return rx_tick_o;
      1: return tx_tick_o;
      2: return rx_sample_o;
      3: return xck_o ^ xck_q;
      4: return xck_i ^ pin_q;
      default: return 1'h1;
    endcase
  endfunction : sig

  // one classic cycle; request held until ack is sampled high
  task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
    int i;
    @(posedge clk_i);
    wb_cyc_i <= 1'h1;
    wb_stb_i <= 1'h1;
    wb_we_i <= we;
    wb_adr_i <= a;
    wb_sel_i <= 4'h1;
    wb_dat_i <= d;
    i = 0;
    do begin @(posedge clk_i); i++; end while (wb_ack_o !== 1'h1 && i < 50);
    q = wb_dat_o;
    `CHK("ack", 1'h1, wb_ack_o)
    wb_cyc_i <= 1'h0;
    wb_stb_i <= 1'h0;
    wb_we_i <= 1'h0;
  endtask : wb

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    wb(1'h1, a, d, q);
  endtask : wr

  task automatic rd(input logic [7:0] a, output logic [31:0] q);
    wb(1'h0, a, 32'h0, q);
  endtask : rd

  // wait for event a, count cycles to event b; bounded so a stall cannot hang
  task automatic gap(input int a, input int b, output int g, output logic [3:0] m, output logic v);
    int i;
    i = 0;
    g = 0;
    m = 4'h0;
    do begin @(posedge clk_i); #1; i++; end while (sig(a) !== 1'h1 && i < 3000);
    v = xck_o;
    do begin
      @(posedge clk_i);
      #1;
      g++;
      if (rx_state_o > m) m = rx_state_o;
    end while (sig(b) !== 1'h1 && g < 3000);
  endtask : gap

  task automatic mode(input logic [3:0] e);
    logic [31:0] q;
    rd(ucg_pkg::ADR_STATUS, q);
    `CHK("mode", e, q[3:0])
  endtask : mode

  task automatic do_reset();
    @(posedge clk_i);
    rst_i <= 1'h1;
    repeat (5) @(posedge clk_i);
    rst_i <= 1'h0;
  endtask : do_reset

  task automatic t_reset();
    logic [31:0] q;
    int g;
    logic [3:0] m;
    logic v;
    for (int a = 0; a < 24; a += 4) begin
      rd(8'(a), q);
      `CHK("reset value", 32'h0, q)
    end
    rd(ucg_pkg::ADR_STATUS, q);
    `CHK("reset mode", 4'h1, q[3:0])
    `CHK("reset count", 12'h000, q[27:16])
    wr(8'h1C, 32'hFF);
    rd(8'h1C, q);
    `CHK("unmapped", 32'h0, q)
    gap(0, 0, g, m, v);
    `CHK("rx gap div 0", 1, g)
    $display("test reset done");
  endtask : t_reset

  task automatic t_async();
    logic [31:0] q;
    int g;
    logic [3:0] m;
    logic v;
    wr(ucg_pkg::ADR_DIV_HI, 32'hFF);
    wr(ucg_pkg::ADR_DIV_LO, 32'hFF);
    rd(ucg_pkg::ADR_DIV_HI, q);
    `CHK("div high", 32'hF, q)
    rd(ucg_pkg::ADR_DIV_LO, q);
    `CHK("div low", 32'hFF, q)
    wr(ucg_pkg::ADR_DIV_HI, 32'h0);
    wr(ucg_pkg::ADR_DIV_LO, 32'h5);
    gap(0, 0, g, m, v);
    `CHK("rx gap", 6, g)
    gap(1, 1, g, m, v);
    `CHK("tx gap normal", 96, g)
    `CHK("states normal", 4'hF, m)
    `CHK("pin idle", 1'h0, xck_oe_o)
    mode(4'h1);
    $display("test async normal done");
  endtask : t_async

  task automatic t_double();
    int g;
    logic [3:0] m;
    logic v;
    wr(ucg_pkg::ADR_CTRL_A, 32'h2);
    gap(1, 1, g, m, v);
    `CHK("tx gap double", 48, g)
    `CHK("states double", 4'h7, m)
    gap(0, 0, g, m, v);
    `CHK("rx gap double", 6, g)
    mode(4'h2);
    $display("test async double done");
  endtask : t_double

  task automatic t_master();
    int g;
    logic [3:0] m;
    logic v, v0;
    wr(ucg_pkg::ADR_CTRL_A, 32'h0);
    wr(ucg_pkg::ADR_PINDIR, 32'h1);
    wr(ucg_pkg::ADR_CTRL_C, 32'h1);
    mode(4'h4);
    `CHK("master drives", 1'h1, xck_oe_o)
    gap(3, 3, g, m, v);
    `CHK("pin toggle gap", 6, g)
    gap(1, 1, g, m, v);
    `CHK("tx gap master", 12, g)
    gap(0, 0, g, m, v);
    `CHK("rx gap master", 6, g)
    gap(1, 2, g, m, v0);
    `CHK("change to sample", 6, g)
    wr(ucg_pkg::ADR_CTRL_C, 32'h3);
    gap(1, 2, g, m, v);
    `CHK("polarity edge", ~v0, v)
    $display("test sync master done");
  endtask : t_master

  task automatic t_slave();
    int g;
    logic [3:0] m;
    logic v;
    peer_pol <= 1'h1;
    wr(ucg_pkg::ADR_PINDIR, 32'h0);
    mode(4'h8);
    `CHK("slave released", 1'h0, xck_oe_o)
    peer_run <= 1'h1;
    gap(4, 0, g, m, v);
    `CHK("sync delay", 1'h1, g inside {[3:5]})
    gap(0, 0, g, m, v);
    `CHK("rx gap slave", 6, g)
    gap(1, 1, g, m, v);
    `CHK("tx gap slave", 12, g)
    peer_run <= 1'h0;
    $display("test sync slave done");
  endtask : t_slave

  task automatic t_pin_idle();
    int g;
    logic [3:0] m;
    logic v;
    wr(ucg_pkg::ADR_CTRL_C, 32'h0);
    wr(ucg_pkg::ADR_PINDIR, 32'h1);
    peer_run <= 1'h1;
    gap(0, 0, g, m, v);
    `CHK("async ignores pin", 6, g)
    `CHK("async no drive", 1'h0, xck_oe_o)
    peer_run <= 1'h0;
    wr(ucg_pkg::ADR_PINDIR, 32'h0);
    $display("test pin unused done");
  endtask : t_pin_idle

  task automatic t_reload();
    int g;
    logic [3:0] m;
    logic v;
    wr(ucg_pkg::ADR_DIV_LO, 32'hC8);
    repeat (50) @(posedge clk_i);
    wr(ucg_pkg::ADR_DIV_LO, 32'hC8);
    gap(5, 0, g, m, v);
    `CHK("reload on low write", 1'h1, g inside {[196:200]})
    wr(ucg_pkg::ADR_POWER, 32'h1);
    gap(5, 0, g, m, v);
    `CHK("power cut freezes", 3000, g)
    wr(ucg_pkg::ADR_POWER, 32'h0);
    gap(0, 0, g, m, v);
    `CHK("rx gap 200", 201, g)
    $display("test reload and power done");
  endtask : t_reload

  initial begin
    repeat (5) @(posedge clk_i);
    rst_i <= 1'h0;
    t_reset();
    t_async();
    t_double();
    t_master();
    t_slave();
    t_pin_idle();
    t_reload();
    do_reset();
    t_reset();
    summarize();
  end
endmodule : tb_usart_clock_generator
